/* logic/scg_sysctl.sv */
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "scg_defines.svh"
// How it works
// - Eight path-select bits; clear bit means port reached via peripheral bus only.
// - Set bit decodes the port at its high-speed alias address instead.
// - Four interrupt sources: oscillator power-up, USB PLL lock, main PLL lock, brown-out.
// - Clear write with mask clears only selected latched sources.
// - Interrupt output is OR of raw bits ANDed with enables.
// - Enable-set sets only named bits; enable-clear clears only named bits.
// - Raw and masked status views readable at same bit positions.
// - Regulator field resets to 2.5 V setting, range plus or minus ten percent.
// - Regulator field holds eleven settings in equal steps; read returns last in-range value written.
// - Gating bit clear at reset: sleep clocks follow run clocking.
// - Gating set: sleep and deep-sleep clocks follow per-peripheral enables.
// - Deep-sleep enables keep values while gating off and do nothing.
module scg_sysctl #(
  parameter int NUM_PORTS = 8,
  parameter int NUM_PERIPH = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic [3:0] irqEventPin,
  input wire logic [1:0] powerMode,
  input wire logic [NUM_PERIPH-1:0] runClockEn,
  input wire logic [31:0] portAccessAddr,
  input wire logic portAccessValid,
  output logic [NUM_PORTS-1:0] portHit,
  output logic portHitFast,
  output logic [NUM_PERIPH-1:0] periphClockEn,
  output logic [3:0] regulatorSetting,
  output logic sysIrq,
  output logic ctlIrq
);

  // Port decode and register layout only cover eight ports and one 32-bit word of peripherals
  if (NUM_PORTS != 8 || NUM_PERIPH < 1 || NUM_PERIPH > 32) begin : gen_bad_params
    $error("scg_sysctl: unsupported parameters");
  end

  // ----------------------------------------
  // Input synchronisers and request bundle
  // ----------------------------------------
  logic [3:0] evtMeta;
  logic [3:0] evtSync;
  logic [3:0] evtPrev;
  logic [1:0] modeMeta;
  logic [1:0] modeSync;
  scg_pkg::scg_req_t req;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      evtMeta <= 4'h0;
      evtSync <= 4'h0;
      evtPrev <= 4'h0;
      modeMeta <= 2'h0;
      modeSync <= 2'h0;
    end else begin
      evtMeta <= irqEventPin;
      evtSync <= evtMeta;
      evtPrev <= evtSync;
      modeMeta <= powerMode;
      modeSync <= modeMeta;
    end
  end

  // Events are rising edges of the synchronised source levels
  logic [3:0] evtPulse;
  assign evtPulse = evtSync & ~evtPrev;

  function automatic logic isWrite(input scg_pkg::scg_req_t r, input logic [7:0] off);
    isWrite = r.wr && (r.addr == off);
  endfunction : isWrite

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [NUM_PORTS-1:0] pathSel;
  logic [3:0] regulator;
  logic gatingOn;
  logic [NUM_PERIPH-1:0] sleepEn;
  logic [NUM_PERIPH-1:0] deepEn;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pathSel <= '0;
      regulator <= `SCG_REG_DEFAULT;
      gatingOn <= 1'b0;
      sleepEn <= '1;
      deepEn <= '0;
    end else begin
      if (isWrite(req, `SCG_OFF_PATHSEL)) begin
        pathSel <= req.wdata[NUM_PORTS-1:0];
      end
      // Out-of-range settings are ignored so the field never leaves the band
      if (isWrite(req, `SCG_OFF_REGULATOR) && req.wdata[3:0] <= `SCG_REG_HIGHEST) begin
        regulator <= req.wdata[3:0];
      end
      if (isWrite(req, `SCG_OFF_GATING)) begin
        gatingOn <= req.wdata[0];
      end
      if (isWrite(req, `SCG_OFF_SLEEP_EN)) begin
        sleepEn <= req.wdata[NUM_PERIPH-1:0];
      end
      if (isWrite(req, `SCG_OFF_DEEP_EN)) begin
        deepEn <= req.wdata[NUM_PERIPH-1:0];
      end
    end
  end

  // ----------------------------------------
  // System-control interrupt sources
  // ----------------------------------------
  logic [3:0] irqRaw;
  logic [3:0] irqEn;
  logic [3:0] next_irqRaw;
  logic [3:0] next_irqEn;

  always_comb begin
    next_irqRaw = irqRaw;
    if (isWrite(req, `SCG_OFF_IRQ_CLEAR)) begin
      next_irqRaw = irqRaw & ~req.wdata[3:0];
    end
    next_irqRaw = next_irqRaw | evtPulse;
  end

  always_comb begin
    next_irqEn = irqEn;
    if (isWrite(req, `SCG_OFF_IRQ_ENSET)) begin
      next_irqEn = next_irqEn | req.wdata[3:0];
    end
    if (isWrite(req, `SCG_OFF_IRQ_ENCLR)) begin
      next_irqEn = next_irqEn & ~req.wdata[3:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irqRaw <= 4'h0;
      irqEn <= 4'h0;
    end else begin
      irqRaw <= next_irqRaw;
      irqEn <= next_irqEn;
    end
  end

  // Built from next values, so a clear shows at the same edge as the write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sysIrq <= 1'b0;
    end else begin
      sysIrq <= |(next_irqRaw & next_irqEn);
    end
  end

  // ----------------------------------------
  // Block event status, read-to-clear
  // ----------------------------------------
  // Events: bit0 regulator written, bit1 unmapped access, bit2 path-select written
  logic [2:0] ctlStatus;
  logic [2:0] ctlMask;
  logic [2:0] ctlEvt;
  logic [2:0] next_ctlStatus;
  logic unmapped;

  always_comb begin
    unmapped = 1'b1;
    case (req.addr)
      `SCG_OFF_PATHSEL, `SCG_OFF_IRQ_RAW, `SCG_OFF_IRQ_MASKED, `SCG_OFF_IRQ_ENSET,
      `SCG_OFF_IRQ_ENCLR, `SCG_OFF_IRQ_CLEAR, `SCG_OFF_REGULATOR, `SCG_OFF_GATING,
      `SCG_OFF_SLEEP_EN, `SCG_OFF_DEEP_EN, `SCG_OFF_STATUS, `SCG_OFF_MASK,
      `SCG_OFF_IRQ_EN: unmapped = 1'b0;
      default: unmapped = 1'b1;
    endcase
  end

  assign ctlEvt = {isWrite(req, `SCG_OFF_PATHSEL), (req.wr || req.rd) && unmapped,
                   isWrite(req, `SCG_OFF_REGULATOR)};

  always_comb begin
    next_ctlStatus = ctlStatus;
    if (req.rd && req.addr == `SCG_OFF_STATUS) begin
      next_ctlStatus = 3'h0;
    end
    next_ctlStatus = next_ctlStatus | ctlEvt;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctlStatus <= 3'h0;
      ctlMask <= 3'h0;
      ctlIrq <= 1'b0;
    end else begin
      ctlStatus <= next_ctlStatus;
      if (isWrite(req, `SCG_OFF_MASK)) begin
        ctlMask <= req.wdata[2:0];
      end
      ctlIrq <= |(next_ctlStatus & (isWrite(req, `SCG_OFF_MASK) ? req.wdata[2:0] : ctlMask));
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0;
    case (req.addr)
      `SCG_OFF_PATHSEL: next_rdata[NUM_PORTS-1:0] = pathSel;
      `SCG_OFF_IRQ_RAW: next_rdata[3:0] = irqRaw;
      `SCG_OFF_IRQ_MASKED: next_rdata[3:0] = irqRaw & irqEn;
      `SCG_OFF_IRQ_EN: next_rdata[3:0] = irqEn;
      `SCG_OFF_REGULATOR: next_rdata[3:0] = regulator;
      `SCG_OFF_GATING: next_rdata[0] = gatingOn;
      `SCG_OFF_SLEEP_EN: next_rdata[NUM_PERIPH-1:0] = sleepEn;
      `SCG_OFF_DEEP_EN: next_rdata[NUM_PERIPH-1:0] = deepEn;
      `SCG_OFF_STATUS: next_rdata[2:0] = ctlStatus;
      `SCG_OFF_MASK: next_rdata[2:0] = ctlMask;
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 32'h0;
    end else begin
      regRdata <= req.rd ? next_rdata : 32'h0;
    end
  end

  // ----------------------------------------
  // GPIO path decode
  // ----------------------------------------
  logic [NUM_PORTS-1:0] next_portHit;
  logic next_portHitFast;

  always_comb begin
    next_portHit = '0;
    next_portHitFast = 1'b0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (portAccessValid) begin
        if (pathSel[i] && portAccessAddr == `SCG_PATH_BASE_FAST + 32'(i) * `SCG_PATH_STRIDE_FAST) begin
          next_portHit[i] = 1'b1;
          next_portHitFast = 1'b1;
        end
        if (!pathSel[i] && portAccessAddr == `SCG_PATH_BASE_PERIPH + 32'(i) * `SCG_PATH_STRIDE_PERIPH) begin
          next_portHit[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      portHit <= '0;
      portHitFast <= 1'b0;
      regulatorSetting <= `SCG_REG_DEFAULT;
    end else begin
      portHit <= next_portHit;
      portHitFast <= next_portHitFast;
      regulatorSetting <= regulator;
    end
  end

  // ----------------------------------------
  // Sleep clock gating
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_PERIPH; g++) begin : gen_gate
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          periphClockEn[g] <= 1'b0;
        end else if (!gatingOn || modeSync == scg_pkg::SCG_RUN) begin
          periphClockEn[g] <= runClockEn[g];
        end else if (modeSync == scg_pkg::SCG_SLEEP) begin
          periphClockEn[g] <= runClockEn[g] & sleepEn[g];
        end else begin
          periphClockEn[g] <= runClockEn[g] & deepEn[g];
        end
      end
    end
  endgenerate

endmodule : scg_sysctl

/* logic/scg_defines.svh */
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SCG_OFF_PATHSEL 8'h00
`define SCG_OFF_IRQ_RAW 8'h04
`define SCG_OFF_IRQ_MASKED 8'h08
`define SCG_OFF_IRQ_ENSET 8'h0c
`define SCG_OFF_IRQ_ENCLR 8'h10
`define SCG_OFF_IRQ_CLEAR 8'h14
`define SCG_OFF_REGULATOR 8'h18
`define SCG_OFF_GATING 8'h1c
`define SCG_OFF_SLEEP_EN 8'h20
`define SCG_OFF_DEEP_EN 8'h24
`define SCG_OFF_STATUS 8'h28
`define SCG_OFF_MASK 8'h2c
`define SCG_OFF_IRQ_EN 8'h30

// ----------------------------------------
// Interrupt bit positions
// ----------------------------------------
`define SCG_BIT_MAIN_OSC_POWERUP 0
`define SCG_BIT_USB_PLL_LOCK 1
`define SCG_BIT_MAIN_PLL_LOCK 2
`define SCG_BIT_BROWNOUT 3

// ----------------------------------------
// Regulator settings, 50 mV steps
// ----------------------------------------
`define SCG_REG_LOWEST 4'h0
`define SCG_REG_DEFAULT 4'h5
`define SCG_REG_HIGHEST 4'ha

`define SCG_PATH_BASE_PERIPH 32'h40004000
`define SCG_PATH_BASE_FAST 32'h40058000
`define SCG_PATH_STRIDE_PERIPH 32'h00001000
`define SCG_PATH_STRIDE_FAST 32'h00001000

`endif

/* logic/scg_pkg.sv */
package scg_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } scg_req_t;

  typedef enum logic [1:0] {
    SCG_RUN,
    SCG_SLEEP,
    SCG_DEEP
  } scg_power_t;
endpackage : scg_pkg

/* verif/scg_core_model.sv */
`timescale 1ns/1ps
module scg_core_model (
  input wire logic clock,
  output logic [7:0] regAddr,
  output logic [31:0] regWdata,
  output logic regWr,
  output logic regRd,
  input wire logic [31:0] regRdata
);
  initial begin
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // Writes are never posted, so a clear lands before the handler moves on
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    regWdata <= ~d;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    // Data stand only in the cycle after the strobe; take them at its closing edge
    @(posedge clock);
    d = regRdata;
  endtask : rd
endmodule : scg_core_model

/* verif/scg_sysctl_sva.sv */
`timescale 1ns/1ps
module scg_sysctl_sva #(
  parameter int NUM_PORTS = 8,
  parameter int NUM_PERIPH = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic [1:0] powerMode,
  input wire logic [NUM_PERIPH-1:0] runClockEn,
  input wire logic portAccessValid,
  input wire logic [NUM_PORTS-1:0] portHit,
  input wire logic portHitFast,
  input wire logic [NUM_PERIPH-1:0] periphClockEn,
  input wire logic [3:0] regulatorSetting,
  input wire logic sysIrq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside its slot");
  a_reg_range: assert property (regulatorSetting <= 4'ha)
    else $error("regulator code out of range");
  a_reg_write: assert property (regWr && regAddr == 8'h18 && regWdata[3:0] <= 4'ha
    |-> ##2 regulatorSetting == 4'($past(regWdata, 2))) else $error("regulator write lost");
  a_reg_hold: assert property (!$past(regWr, 2) |-> $stable(regulatorSetting))
    else $error("regulator changed without write");
  a_hit_onehot: assert property ($onehot0(portHit))
    else $error("more than one port hit");
  a_hit_cause: assert property (|portHit |-> $past(portAccessValid))
    else $error("port hit without access");
  a_fast_hit: assert property (portHitFast |-> |portHit)
    else $error("fast flag without hit");
  a_irq_off: assert property (regWr && regAddr == 8'h10 && regWdata[3:0] == 4'hf |=> !sysIrq)
    else $error("interrupt with all sources disabled");
  a_gate_run: assert property ((powerMode == 2'h0 && $stable(runClockEn)) [*4]
    |-> periphClockEn == runClockEn) else $error("run clocks not followed");
endmodule : scg_sysctl_sva

bind scg_sysctl scg_sysctl_sva #(.NUM_PORTS(NUM_PORTS), .NUM_PERIPH(NUM_PERIPH)) u_scg_sysctl_sva (
  .clock, .rst_b, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .powerMode, .runClockEn,
  .portAccessValid, .portHit, .portHitFast, .periphClockEn, .regulatorSetting, .sysIrq);

/* verif/scg_sysctl_tb_top.sv */
`timescale 1ns/1ps
`include "scg_defines.svh"
module scg_sysctl_tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] regAddr, portHit;
  logic [31:0] regWdata, regRdata, periphClockEn, rv;
  logic [31:0] runClockEn = 32'h0000ff0f;
  logic [31:0] portAccessAddr = 32'h0;
  logic regWr, regRd, portHitFast, sysIrq, ctlIrq;
  logic portAccessValid = 1'b0;
  logic [3:0] irqEventPin = 4'h0;
  logic [3:0] regulatorSetting;
  logic [1:0] powerMode = 2'h0;
  int errorCnt = 0;
  int nChecks = 0;
  int cycles = 0;

  always #12.5 clock = ~clock;

  scg_sysctl u_scg_sysctl (.clock, .rst_b, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .irqEventPin, .powerMode, .runClockEn, .portAccessAddr, .portAccessValid, .portHit,
    .portHitFast, .periphClockEn, .regulatorSetting, .sysIrq, .ctlIrq);
  scg_core_model u_scg_core_model (.clock, .regAddr, .regWdata, .regWr, .regRd, .regRdata);

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    u_scg_core_model.rd(a, rv);
    chk(n, e, rv);
  endtask : rchk

  task automatic completeRun();
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : completeRun

  task automatic testRegulator();
    rchk("regDefault", 8'h18, 32'h5);
    for (int i = 0; i <= 10; i++) begin
      u_scg_core_model.wr(8'h18, 32'(i));
      rchk("regRead", 8'h18, 32'(i));
      chk("regPort", 32'(i), 32'(regulatorSetting));
    end
    u_scg_core_model.wr(8'h18, 32'hb);
    rchk("regRefused", 8'h18, 32'ha);
  endtask : testRegulator

  task automatic testStatus();
    u_scg_core_model.rd(8'h28, rv);
    u_scg_core_model.wr(8'h2c, 32'h1);
    u_scg_core_model.wr(8'h18, 32'h5);
    chk("ctlIrqSet", 32'h1, 32'(ctlIrq));
    rchk("status", 8'h28, 32'h1);
    chk("ctlIrqClr", 32'h0, 32'(ctlIrq));
    rchk("unmapped", 8'h3c, 32'h0);
    rchk("statusUnmapped", 8'h28, 32'h2);
  endtask : testStatus

  task automatic testIrq();
    irqEventPin <= 4'h4;
    repeat (5) @(posedge clock);
    rchk("raw", 8'h04, 32'h4);
    chk("irqDisabled", 32'h0, 32'(sysIrq));
    u_scg_core_model.wr(8'h0c, 32'h4);
    chk("irqEnabled", 32'h1, 32'(sysIrq));
    rchk("masked", 8'h08, 32'h4);
    u_scg_core_model.wr(8'h0c, 32'h9);
    u_scg_core_model.wr(8'h10, 32'h4);
    rchk("enables", 8'h30, 32'h9);
    irqEventPin <= 4'hf;
    repeat (5) @(posedge clock);
    rchk("rawAll", 8'h04, 32'hf);
    rchk("maskedAll", 8'h08, 32'h9);
    u_scg_core_model.wr(8'h14, 32'h9);
    rchk("rawPartClr", 8'h04, 32'h6);
    chk("irqAfterClr", 32'h0, 32'(sysIrq));
    // Line the clear up with the edge that latches a fresh event
    irqEventPin <= 4'he;
    repeat (4) @(posedge clock);
    irqEventPin <= 4'hf;
    repeat (2) @(posedge clock);
    u_scg_core_model.wr(8'h14, 32'h1);
    rchk("rawSetWins", 8'h04, 32'h7);
    u_scg_core_model.wr(8'h10, 32'hf);
  endtask : testIrq

  task automatic probe(input logic [31:0] a, input logic [8:0] e);
    portAccessAddr <= a;
    portAccessValid <= 1'b1;
    @(posedge clock);
    portAccessValid <= 1'b0;
    @(posedge clock);
    chk("portHit", 32'(e), 32'({portHitFast, portHit}));
  endtask : probe

  task automatic testPath();
    u_scg_core_model.wr(8'h00, 32'h4);
    rchk("pathSel", 8'h00, 32'h4);
    probe(`SCG_PATH_BASE_FAST + 32'h2000, 9'h104);
    probe(`SCG_PATH_BASE_PERIPH + 32'h2000, 9'h000);
    probe(`SCG_PATH_BASE_PERIPH + 32'h3000, 9'h008);
    probe(`SCG_PATH_BASE_FAST + 32'h3000, 9'h000);
  endtask : testPath

  task automatic testGating();
    powerMode <= 2'h1;
    repeat (4) @(posedge clock);
    chk("sleepUngated", 32'h0000ff0f, periphClockEn);
    u_scg_core_model.wr(8'h24, 32'h5);
    rchk("deepHeld", 8'h24, 32'h5);
    powerMode <= 2'h2;
    repeat (4) @(posedge clock);
    chk("deepUngated", 32'h0000ff0f, periphClockEn);
    u_scg_core_model.wr(8'h1c, 32'h1);
    repeat (4) @(posedge clock);
    chk("deepGated", 32'h5, periphClockEn);
    u_scg_core_model.wr(8'h20, 32'h3);
    powerMode <= 2'h1;
    repeat (4) @(posedge clock);
    chk("sleepGated", 32'h3, periphClockEn);
    powerMode <= 2'h3;
    repeat (4) @(posedge clock);
    chk("deepAltGated", 32'h5, periphClockEn);
    powerMode <= 2'h0;
    repeat (6) @(posedge clock);
  endtask : testGating

  // Ceiling well above the roughly 170 cycles the scenarios need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errorCnt++;
      completeRun();
    end
  end

  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    testRegulator();
    testStatus();
    testIrq();
    testPath();
    testGating();
    completeRun();
  end
endmodule : scg_sysctl_tb_top
